// File: brap_device.sv
// brap_device: buffer ram, port pointers, byte counter, status and irq of the controller
// assumes: sys_clk is the core clock; link strobes come one cycle wide from the processor
//
// Functional notes
// - 2eh reads second iso list pending bytes
// - first iso length register reports bytes 15:0
// - processor loads counter from readback length
// - iso port: even byte high, odd low
// - processor sends 40h/c0h once, then words
// - ack port: odd byte high, even low
// - processor sends 41h/c1h once, then words
// - processor sets count, checks status first
// - pointer advances two bytes per word
// - pointer reaching count raises end of transfer
// - ram byte addressed, port moves 16 bits
// - core clock is pll times six mhz
// - status holds done bits 5..3, full 2..0
// - ack plus twice iso within 1000h
`timescale 1ns/10ps
module brap_device
  import brap_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  brap_link_if.dev         link,
  input  wire logic        iso_a_fill,
  input  wire logic        iso_b_fill,
  input  wire logic [15:0] fill_bytes,
  input  wire logic        ack_consumed,
  input  wire logic [15:0] irq_mask,
  output logic      [15:0] iso_a_pending_bytes,
  output logic      [15:0] iso_b_pending_bytes
);
  import brap_pkg::*;

  // which buffer the open port points at; none means port words are dropped
  typedef enum logic [1:0] {BRAP_NONE, BRAP_ISO_A, BRAP_ISO_B, BRAP_ACK} brap_sel_e;

  logic [7:0]     ram [RAM_BYTES];
  brap_sel_e      sel_reg;
  logic           sel_rd_reg;
  logic [AW-1:0]  ptr_reg;
  logic [AW-1:0]  base_reg;
  logic [15:0]    xfer_cnt_reg;
  logic [15:0]    rdata_reg;
  logic [5:0]     status_reg;
  logic [15:0]    irq_stat_reg;
  logic           port_access;
  logic           end_of_transfer;
  logic [7:0]     cmd_lat_reg;
  logic [15:0]    offs;
  logic [AW-1:0]  next_ptr;

  // an iso read drains buffer b first while it holds data; writes always fill buffer a
  function automatic logic iso_pick_b(input logic [7:0] code, input logic [15:0] b_bytes);
    iso_pick_b = ~code[7] && b_bytes != 16'h0000;
  endfunction

  // the core clock is assumed already multiplied; sys_clk stands for it
  // a word with no open port is dropped; software sees it only as a short count
  assign port_access = clk_en && (link.data_wr || link.data_rd) && sel_reg != BRAP_NONE;
  assign next_ptr    = ptr_reg + PTR_STEP;
  assign offs        = 16'(next_ptr - base_reg);
  assign end_of_transfer         = port_access && offs == xfer_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // command decode and port pointer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sel_reg    <= BRAP_NONE;
      sel_rd_reg <= 1'b0;
      ptr_reg    <= '0;
      base_reg   <= '0;
    end else if (clk_en) begin
      if (link.cmd_valid) begin
        sel_rd_reg <= ~link.cmd_code[7];
        unique case (link.cmd_code)
          CMD_ISO_PORT_RD, CMD_ISO_PORT_WR: begin
            sel_reg  <= iso_pick_b(link.cmd_code, iso_b_pending_bytes) ? BRAP_ISO_B
                                                                       : BRAP_ISO_A;
            base_reg <= iso_pick_b(link.cmd_code, iso_b_pending_bytes) ? ISO_B_BASE
                                                                       : ISO_A_BASE;
            ptr_reg  <= iso_pick_b(link.cmd_code, iso_b_pending_bytes) ? ISO_B_BASE
                                                                       : ISO_A_BASE;
          end
          CMD_ACK_PORT_RD, CMD_ACK_PORT_WR: begin
            sel_reg  <= BRAP_ACK;
            base_reg <= ACK_BASE;
            ptr_reg  <= ACK_BASE;
          end
          default: sel_reg <= BRAP_NONE;
        endcase
      end else if (port_access) begin
        ptr_reg <= next_ptr;
        if (end_of_transfer) begin
          sel_reg <= BRAP_NONE; // further words are ignored until a new command
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transfer byte counter, written by each data word that follows command a2h until the next command
  // a count of zero matches only after 2048 words, when the 12-bit pointer wraps back to its base
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_lat_reg  <= 8'h00;
      xfer_cnt_reg <= RESET_WORD;
    end else if (clk_en) begin
      if (link.cmd_valid) begin
        cmd_lat_reg <= link.cmd_code;
      end else if (link.data_wr && cmd_lat_reg == CMD_XFER_CNT_WR) begin
        xfer_cnt_reg <= link.wdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // buffer ram writes, lanes per port type
  // no reset on the ram: its contents are undefined until software writes them
  always_ff @(posedge sys_clk) begin
    if (clk_en && port_access && link.data_wr && !sel_rd_reg) begin
      if (sel_reg == BRAP_ACK) begin
        ram[ptr_reg]                 <= link.wdata[7:0];
        ram[ptr_reg | AW'(1)]        <= link.wdata[15:8];
      end else begin
        ram[ptr_reg]                 <= link.wdata[15:8];
        ram[ptr_reg | AW'(1)]        <= link.wdata[7:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read data: register reads answer the command, port reads answer each strobe
  // a port read answers from the pointer before it advances
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_reg <= RESET_WORD;
    end else if (clk_en) begin
      if (link.cmd_valid) begin
        unique case (link.cmd_code)
          CMD_ISO_B_LEN_RD: rdata_reg <= iso_b_pending_bytes;
          CMD_ISO_A_LEN_RD: rdata_reg <= iso_a_pending_bytes;
          CMD_STATUS_RD:    rdata_reg <= {10'h000, status_reg};
          CMD_IRQ_RD:       rdata_reg <= irq_stat_reg;
          default:          rdata_reg <= rdata_reg;
        endcase
      end else if (port_access && link.data_rd) begin
        rdata_reg <= brap_lane(ram[ptr_reg], ram[ptr_reg | AW'(1)],
                               sel_reg == BRAP_ACK);
      end
    end
  end
  assign link.rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // pending lengths and buffer status; a fill from the usb side wins over a drain
  // done bits stay set until reset: clearing them belongs to the usb side
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      iso_a_pending_bytes <= RESET_WORD;
      iso_b_pending_bytes <= RESET_WORD;
      status_reg          <= 6'h00;
    end else if (clk_en) begin
      if (end_of_transfer) begin
        unique case (sel_reg)
          BRAP_ISO_A: begin
            iso_a_pending_bytes          <= RESET_WORD;
            status_reg[ST_ISO_A_FULL_BIT] <= sel_rd_reg ? 1'b0 : 1'b1;
          end
          BRAP_ISO_B: begin
            iso_b_pending_bytes          <= RESET_WORD;
            status_reg[ST_ISO_B_FULL_BIT] <= sel_rd_reg ? 1'b0 : 1'b1;
          end
          BRAP_ACK: status_reg[ST_ACK_FULL_BIT] <= sel_rd_reg ? 1'b0 : 1'b1;
          default: ;
        endcase
      end
      if (iso_a_fill) begin
        iso_a_pending_bytes                <= fill_bytes;
        status_reg[ST_ISO_A_DONE_BIT]      <= 1'b1;
      end
      if (iso_b_fill) begin
        iso_b_pending_bytes                <= fill_bytes;
        status_reg[ST_ISO_B_DONE_BIT]      <= 1'b1;
      end
      if (ack_consumed) begin
        status_reg[ST_ACK_DONE_BIT]        <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status: write one to clear, a same-cycle set wins
  // the mask only gates the output, so a masked event still shows in the status read
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_stat_reg <= RESET_WORD;
    end else if (clk_en) begin
      if (link.data_wr && cmd_lat_reg == CMD_IRQ_CLR_WR && !link.cmd_valid) begin
        irq_stat_reg <= irq_stat_reg & ~link.wdata;
      end
      if (end_of_transfer) begin
        irq_stat_reg[IRQ_ALL_EOT_BIT] <= 1'b1;
      end
    end
  end
  assign link.irq = |(irq_stat_reg & irq_mask);
endmodule

// File: brap_pkg.sv
// brap_pkg: command codes, field positions and sizes for the buffer ram access port
// assumes: shared by the device end, the processor end, the checker and the testbench
package brap_pkg;
  localparam logic [7:0]  CMD_ISO_B_LEN_RD  = 8'h2e;
  localparam logic [7:0]  CMD_ISO_A_LEN_RD  = 8'h2d;
  localparam logic [7:0]  CMD_STATUS_RD     = 8'h2c;
  localparam logic [7:0]  CMD_ISO_PORT_RD   = 8'h40;
  localparam logic [7:0]  CMD_ISO_PORT_WR   = 8'hc0;
  localparam logic [7:0]  CMD_ACK_PORT_RD   = 8'h41;
  localparam logic [7:0]  CMD_ACK_PORT_WR   = 8'hc1;
  localparam logic [7:0]  CMD_XFER_CNT_WR   = 8'ha2;
  localparam logic [7:0]  CMD_IRQ_RD        = 8'h24;
  localparam logic [7:0]  CMD_IRQ_CLR_WR    = 8'ha4;
  localparam int          RAM_BYTES         = 4096;
  localparam int          AW                = 12;
  localparam logic [11:0] ISO_A_BASE        = 12'h000;
  localparam logic [11:0] ISO_B_BASE        = 12'h400;
  localparam logic [11:0] ACK_BASE          = 12'h800;
  localparam int          IRQ_ALL_EOT_BIT   = 2;
  localparam int          ST_ACK_DONE_BIT   = 5;
  localparam int          ST_ISO_B_DONE_BIT = 4;
  localparam int          ST_ISO_A_DONE_BIT = 3;
  localparam int          ST_ACK_FULL_BIT   = 2;
  localparam int          ST_ISO_B_FULL_BIT = 1;
  localparam int          ST_ISO_A_FULL_BIT = 0;
  localparam logic [15:0] RESET_WORD        = 16'h0000;
  localparam logic [11:0] PTR_STEP          = 12'h002;
  localparam int          CORE_CLK_MHZ      = 48;
  localparam int          XTAL_MHZ          = 6;
  localparam int          PLL_MULT          = CORE_CLK_MHZ / XTAL_MHZ;
  // swap lanes: the ack port carries the odd byte high, iso the even byte high
  function automatic logic [15:0] brap_lane(input logic [7:0] even_b,
                                            input logic [7:0] odd_b,
                                            input logic       ack);
    brap_lane = ack ? {odd_b, even_b} : {even_b, odd_b};
  endfunction
endpackage

// File: brap_link_if.sv
// brap_link_if: command/data link between processor end and device end
// assumes: one clock; cmd_valid and data strobes are one-cycle pulses
`timescale 1ns/10ps
interface brap_link_if;
  logic        cmd_valid;
  logic [7:0]  cmd_code;
  logic        data_wr;
  logic        data_rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        irq;
  modport dev  (input cmd_valid, input cmd_code, input data_wr, input data_rd,
                input wdata, output rdata, output irq);
  modport proc (output cmd_valid, output cmd_code, output data_wr, output data_rd,
                output wdata, input rdata, input irq);
endinterface

// File: brap_processor.sv
// brap_processor: processor end that turns software register writes into link strobes and captures read data
// assumes: software drives the plain register port; one clock shared with the device
`timescale 1ns/10ps
module brap_processor
  import brap_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clk_en,
  brap_link_if.proc        link,
  input  wire logic [3:0]  sw_addr,
  input  wire logic [15:0] sw_wdata,
  input  wire logic        sw_wr,
  input  wire logic        sw_rd,
  output logic      [15:0] sw_rdata,
  output logic             irq_out
);
  import brap_pkg::*;

  // sw map: 0 send command (low byte), 1 write data word, 2 read data strobe,
  //         3 last read word, 4 irq line
  localparam logic [3:0] SW_CMD   = 4'h0;
  localparam logic [3:0] SW_WDATA = 4'h1;
  localparam logic [3:0] SW_RDSTB = 4'h2;
  localparam logic [3:0] SW_RWORD = 4'h3;
  localparam logic [3:0] SW_IRQ   = 4'h4;

  logic [15:0] rword_reg;
  logic        rd_pend_reg;
  logic [15:0] sw_rdata_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // link strobes follow software writes directly; software orders the sequence
  // (count, status check, one command, then words)
  assign link.cmd_valid = clk_en && sw_wr && sw_addr == SW_CMD;
  assign link.cmd_code  = sw_wdata[7:0];
  assign link.data_wr   = clk_en && sw_wr && sw_addr == SW_WDATA;
  assign link.data_rd   = clk_en && sw_wr && sw_addr == SW_RDSTB;
  assign link.wdata     = sw_wdata;

  // capture device answer one cycle after the strobe or command
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_pend_reg <= 1'b0;
      rword_reg   <= RESET_WORD;
    end else if (clk_en) begin
      rd_pend_reg <= link.data_rd || link.cmd_valid;
      if (rd_pend_reg) begin
        rword_reg <= link.rdata;
      end
    end
  end

  // software read port, data one cycle later
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sw_rdata_reg <= RESET_WORD;
    end else if (clk_en && sw_rd) begin
      unique case (sw_addr)
        SW_RWORD: sw_rdata_reg <= rd_pend_reg ? link.rdata : rword_reg;
        SW_IRQ:   sw_rdata_reg <= {15'h0000, link.irq};
        default:  sw_rdata_reg <= RESET_WORD;
      endcase
    end
  end
  assign sw_rdata = sw_rdata_reg;
  assign irq_out  = link.irq;
endmodule

// File: brap_chk.sv
// brap_chk: assertions on the link between processor end and device end
// assumes: signals of brap_link_if plus the device's mask and length ports, one clock
`timescale 1ns/10ps
module brap_chk (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic        data_wr,
  input wire logic        data_rd,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        irq,
  input wire logic [15:0] irq_mask,
  input wire logic [15:0] iso_a_pending_bytes,
  input wire logic [15:0] iso_b_pending_bytes
);
  import brap_pkg::*;
  logic        arm_reg;
  logic        open_reg;
  logic [15:0] cnt_reg;
  logic [15:0] moved_reg;
  logic        port_cmd;
  logic        last_word;
  //////////////////////////////////////////////////////////////////////////
  // shadow of counter and moved bytes; any new command other than a port command closes the port
  assign port_cmd = cmd_valid && (cmd_code == CMD_ISO_PORT_RD || cmd_code == CMD_ISO_PORT_WR
                    || cmd_code == CMD_ACK_PORT_RD || cmd_code == CMD_ACK_PORT_WR);
  assign last_word = open_reg && (data_wr || data_rd) && (moved_reg + 16'h0002 == cnt_reg);
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      arm_reg <= 1'b0;
      open_reg <= 1'b0;
      cnt_reg <= 16'h0000;
      moved_reg <= 16'h0000;
    end else if (cmd_valid) begin
      arm_reg <= (cmd_code == CMD_XFER_CNT_WR);
      open_reg <= port_cmd;
      moved_reg <= 16'h0000;
    end else if (data_wr && arm_reg) begin
      arm_reg <= 1'b0;
      cnt_reg <= wdata;
    end else if (open_reg && (data_wr || data_rd)) begin
      moved_reg <= moved_reg + 16'h0002;
      open_reg <= !last_word;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_len_a; cmd_valid && cmd_code == CMD_ISO_A_LEN_RD; endsequence
  sequence s_len_b; cmd_valid && cmd_code == CMD_ISO_B_LEN_RD; endsequence
  sequence s_last; last_word && irq_mask[IRQ_ALL_EOT_BIT]; endsequence
  property p_rst_clear;
    @(posedge sys_clk) disable iff (1'b0) rst |=> rdata == RESET_WORD && !irq;
  endproperty
  property p_len_a; s_len_a |=> rdata == $past(iso_a_pending_bytes); endproperty
  property p_len_b; s_len_b |=> rdata == $past(iso_b_pending_bytes); endproperty
  property p_eot_irq; s_last |=> irq; endproperty
  property p_irq_rise; $rose(irq) |-> $past(last_word) || $changed(irq_mask); endproperty
  property p_irq_fall; $fell(irq) |-> $past(data_wr) || $changed(irq_mask); endproperty
  property p_rdata_hold; !cmd_valid && !data_rd |=> $stable(rdata); endproperty
  property p_one_strobe; !(cmd_valid && (data_wr || data_rd)) && !(data_wr && data_rd); endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("link not cleared by reset");
  a_len_a: assert property (p_len_a) else $error("first length read wrong");
  a_len_b: assert property (p_len_b) else $error("second length read wrong");
  a_eot_irq: assert property (p_eot_irq) else $error("no irq at end of transfer");
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose with no cause");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell with no clear");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_one_strobe: assert property (p_one_strobe) else $error("strobes overlap");
endmodule

// File: buffer_ram_access_port_tb.sv
// buffer_ram_access_port_tb: drives the software port, checks read data from a queue
// assumes: processor and device joined by brap_link_if; software read data one cycle late
`timescale 1ns/10ps
module buffer_ram_access_port_tb;
  import brap_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic [3:0]  sw_addr = 4'h0;
  logic [15:0] sw_wdata = 16'h0000;
  logic        sw_wr = 1'b0;
  logic        sw_rd = 1'b0;
  logic        rd_seen = 1'b0;
  logic        iso_a_fill = 1'b0;
  logic        iso_b_fill = 1'b0;
  logic [15:0] fill_bytes = 16'h0000;
  logic        ack_consumed = 1'b0;
  logic [15:0] irq_mask = 16'h0004;
  logic [15:0] sw_rdata;
  logic        irq_out;
  logic [15:0] iso_a_pending_bytes;
  logic [15:0] iso_b_pending_bytes;
  logic [15:0] exp_q[$];
  logic [15:0] words[4];
  logic [15:0] len_a;
  logic [15:0] len_b;
  int          n_fail = 0;
  int          n_compared = 0;
  brap_link_if link ();
  brap_device brap_device_i (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .link(link),
    .iso_a_fill(iso_a_fill), .iso_b_fill(iso_b_fill), .fill_bytes(fill_bytes),
    .ack_consumed(ack_consumed), .irq_mask(irq_mask),
    .iso_a_pending_bytes(iso_a_pending_bytes), .iso_b_pending_bytes(iso_b_pending_bytes));
  brap_processor brap_processor_i (.sys_clk(sys_clk), .rst(rst), .clk_en(1'b1), .link(link),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata), .irq_out(irq_out));
  brap_chk brap_chk_i (.sys_clk(sys_clk), .rst(rst), .cmd_valid(link.cmd_valid),
    .cmd_code(link.cmd_code), .data_wr(link.data_wr), .data_rd(link.data_rd),
    .wdata(link.wdata), .rdata(link.rdata), .irq(link.irq), .irq_mask(irq_mask),
    .iso_a_pending_bytes(iso_a_pending_bytes), .iso_b_pending_bytes(iso_b_pending_bytes));
  always #20 sys_clk = ~sys_clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // each access leaves a quiet edge so no strobe is set twice in one step
  task automatic sw_write(input logic [3:0] a, input logic [15:0] d);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge sys_clk);
    sw_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic sw_read(input logic [3:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge sys_clk);
    sw_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic cmd(input logic [7:0] c);
    sw_write(4'h0, {8'h00, c});
  endtask
  task automatic link_read(input logic [7:0] c, input logic [15:0] exp);
    cmd(c);
    sw_read(4'h3, exp);
  endtask
  task automatic set_count(input logic [15:0] n);
    cmd(CMD_XFER_CNT_WR);
    sw_write(4'h1, n);
  endtask
  task automatic chk_irq(input logic exp);
    @(negedge sys_clk);
    chk({15'h0000, irq_out}, {15'h0000, exp});
    @(posedge sys_clk);
  endtask
  task automatic irq_clear();
    cmd(CMD_IRQ_CLR_WR);
    sw_write(4'h1, 16'h0004);
    chk_irq(1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // watcher: read data is checked in the cycle after the strobe only; sw_rdata holds it until the next read
  always @(posedge sys_clk) rd_seen <= sw_rd;
  always @(negedge sys_clk) begin
    if (rd_seen) begin
      if (exp_q.size() == 0) begin
        n_fail++;
        $display("unexpected read at %0t: got %h, no read expected", $time, sw_rdata);
      end else begin
        chk(sw_rdata, exp_q.pop_front());
      end
    end
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    $display("unexpected timeout at %0t", $time);
    finish_test();
  end
  initial begin
    void'($urandom(48245));
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    link_read(CMD_ISO_B_LEN_RD, RESET_WORD);
    // p 0 is the iso port, p 1 the ack port with the irq masked off
    for (int p = 0; p < 2; p++) begin
      foreach (words[i]) words[i] = 16'($urandom);
      irq_mask <= p ? 16'h0000 : 16'h0004;
      set_count(16'h0008);
      link_read(CMD_STATUS_RD, 16'h0000);
      cmd(p ? CMD_ACK_PORT_WR : CMD_ISO_PORT_WR);
      foreach (words[i]) begin
        chk_irq(1'b0);
        sw_write(4'h1, words[i]);
      end
      chk_irq(p == 0);
      link_read(CMD_IRQ_RD, 16'h0004);
      irq_mask <= 16'h0004;
      chk_irq(1'b1);
      sw_read(4'h4, 16'h0001);
      irq_clear();
      set_count(16'h0008);
      link_read(CMD_STATUS_RD, p ? 16'h0004 : 16'h0001);
      cmd(p ? CMD_ACK_PORT_RD : CMD_ISO_PORT_RD);
      foreach (words[i]) begin
        sw_write(4'h2, 16'h0000);
        sw_read(4'h3, words[i]);
      end
      chk_irq(1'b1);
      irq_clear();
    end
    len_a = 16'(($urandom % 4 + 1) * 2); // short lengths stay inside each buffer
    len_b = 16'(($urandom % 4 + 1) * 2);
    fill_bytes <= len_b;
    iso_b_fill <= 1'b1;
    ack_consumed <= 1'b1;
    @(posedge sys_clk);
    fill_bytes <= len_a;
    iso_b_fill <= 1'b0;
    ack_consumed <= 1'b0;
    iso_a_fill <= 1'b1;
    @(posedge sys_clk);
    iso_a_fill <= 1'b0;
    @(posedge sys_clk);
    link_read(CMD_ISO_B_LEN_RD, len_b);
    link_read(CMD_ISO_A_LEN_RD, len_a);
    set_count(len_b);
    link_read(CMD_STATUS_RD, 16'h0038);
    cmd(CMD_ISO_PORT_RD);
    for (int i = 0; i < len_b / 2; i++) sw_write(4'h2, 16'h0000);
    chk_irq(1'b1);
    link_read(CMD_ISO_B_LEN_RD, 16'h0000);
    repeat (3) @(posedge sys_clk);
    chk(16'(exp_q.size()), 16'h0000);
    finish_test();
  end
endmodule
